/* esc_checker.sv */
// Purpose: Parse and check an enclave_signature_structure for the leaf
// Assumes: Software copies the structure into the window and writes the
//          digest of the signed fields before it starts a check
// Notes:   RSA step is shift-add, one bit per clock, four products
`timescale 1ns/100ps
`include "esc_defs.svh"
// Notes on behaviour
// - Measurement digest is eight 32-bit words, each stored low byte first.
// - Each 3072-bit integer spans 384 bytes, least significant byte first.
// - Public exponent field at 512 must hold three; cube is used.
// - Structure address must be page aligned, else the check is refused.
// - First header at offset 0 must match its fixed 16-byte pattern.
// - Second header at offset 24 must match its fixed 16-byte pattern.
// - Vendor word at 16 is zero or the processor maker's code.
// - Modulus is taken from the 384 bytes at offset 128.
// - Signature at offset 516 is the value raised to the exponent.
// - Feature select at 900 and its enforce mask at 904.
// - Zero capability word demands a zero feature select.
// - Control-flow bytes at 908 and 909 must be zero without capability.
// - Attributes from offset 928, their enforce mask from offset 944.
// - Expected enclave measurement is the 32 bytes at offset 960.
// - Product ident, version, family and extended ident are extracted.
// - First quotient at 1040, second at 1424, 384 bytes each.
// - Software word at 40 carries no meaning to the checker.
// - Signed fields form the message; key, signature, quotients do not.
module esc_checker
  import esc_pkg::*;
#(
  parameter logic [31:0] MAKER_VENDOR = 32'h00005a5a  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  // Register port
  input  wire logic [`ESC_ADDR_BITS-1:0] addr,
  input  wire logic [31:0]               wr_data,
  input  wire logic                      wr_strobe,
  input  wire logic                      rd_strobe,
  output logic      [31:0]               rd_data_q,
  // Result towards the leaf logic
  output logic                           busy_q,
  output logic                           done_q,
  output logic                           pass_q,
  output esc_fields_t                    fields_q
);
  localparam int NB = `ESC_INT_BITS;
  localparam int IW = `ESC_IDX_BITS;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic in_span(input logic [IW-1:0] idx,
                                   input logic [IW-1:0] lo,
                                   input int            n);
    in_span = (idx >= lo) && ({1'b0, idx} < ({1'b0, lo} + (IW+1)'(n)));
  endfunction

  function automatic logic [31:0] fixed_word(input logic [IW-1:0] idx);
    case (idx)
      `ESC_W(`ESC_OFF_HDR1):      fixed_word = `ESC_HDR1_W0;
      `ESC_W(`ESC_OFF_HDR1) + 9'h1: fixed_word = `ESC_HDR1_W1;
      `ESC_W(`ESC_OFF_HDR1) + 9'h2: fixed_word = `ESC_HDR1_W2;
      `ESC_W(`ESC_OFF_HDR1) + 9'h3: fixed_word = `ESC_HDR1_W3;
      `ESC_W(`ESC_OFF_HDR2):      fixed_word = `ESC_HDR2_W0;
      `ESC_W(`ESC_OFF_HDR2) + 9'h1: fixed_word = `ESC_HDR2_W1;
      `ESC_W(`ESC_OFF_HDR2) + 9'h2: fixed_word = `ESC_HDR2_W2;
      `ESC_W(`ESC_OFF_HDR2) + 9'h3: fixed_word = `ESC_HDR2_W3;
      default:                    fixed_word = 32'h00000000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  esc_state_t              state_q;
  esc_errors_t             err_q;
  logic                    frame_cap_q;
  logic                    cflow_cap_q;
  logic [31:0]             base_q;
  logic [31:0]             digest_q [`ESC_DIGEST_WORDS];
  logic [IW-1:0]           load_idx_q;
  logic [IW-1:0]           widx_q;
  logic                    vld_q;
  logic [31:0]             word;
  logic [NB-1:0]           mod_q;
  logic [NB-1:0]           sig_q;
  logic [NB-1:0]           q1_q;
  logic [NB-1:0]           q2_q;
  logic [2*NB-1:0]         acc_q;
  logic [2*NB-1:0]         ma_q;
  logic [NB-1:0]           mb_q;
  logic [2*NB-1:0]         hold_q;
  logic [`ESC_CNT_BITS-1:0] cnt_q;
  logic [1:0]              phase_q;

  logic                    start;
  logic                    win_wr;
  logic                    issue;
  logic                    last_word;
  logic                    prod_done;
  logic [2*NB-1:0]         acc_d;
  logic [2*NB:0]           diff;
  logic                    diff_bad;
  logic [NB-1:0]           em;
  logic [NB-1:0]           next_a;
  logic [NB-1:0]           next_b;
  logic [255:0]            digest_flat;

  assign start  = wr_strobe && (addr == `ESC_REG_CTRL) &&
                  wr_data[`ESC_CTRL_START] && (state_q == ESC_IDLE);
  // Window writes during a check are dropped so the walk sees one image
  assign win_wr = wr_strobe && (state_q == ESC_IDLE) &&
                  (addr >= `ESC_REG_WINDOW) &&
                  (addr < `ESC_REG_WINDOW + 11'(`ESC_STRUCT_WORDS));
  assign issue  = (state_q == ESC_LOAD) &&
                  (load_idx_q < IW'(`ESC_STRUCT_WORDS));
  assign last_word = vld_q && (widx_q == IW'(`ESC_STRUCT_WORDS - 1));

  esc_word_mem #(
    .WIDTH (32),
    .DEPTH (`ESC_STRUCT_WORDS),
    .AW    (IW)
  ) u_mem (
    .mclk      (mclk),
    .wr_en     (win_wr),
    .wr_addr   (IW'(addr - `ESC_REG_WINDOW)),
    .wr_data   (wr_data),
    .rd_en     (issue),
    .rd_addr   (load_idx_q),
    .rd_data_q (word)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ESC_IDLE;
    end else begin
      case (state_q)
        ESC_IDLE: begin
          if (start) begin
            if (base_q[`ESC_PAGE_BITS-1:0] != '0) begin
              state_q <= ESC_DONE;
            end else begin
              state_q <= ESC_LOAD;
            end
          end
        end
        ESC_LOAD: begin
          if (last_word) begin
            state_q <= ESC_MUL;
          end
        end
        ESC_MUL: begin
          if (prod_done && (phase_q == 2'd3)) begin
            state_q <= ESC_DONE;
          end
        end
        ESC_DONE: state_q <= ESC_IDLE;
        default:  state_q <= ESC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      pass_q <= 1'b0;
    end else begin
      busy_q <= (state_q == ESC_IDLE) ? start : (state_q != ESC_DONE);
      done_q <= (state_q == ESC_DONE);
      if (start) begin
        pass_q <= 1'b0;
      end else if (state_q == ESC_DONE) begin
        pass_q <= (err_q == '0);
      end
    end
  end

  // ----------------------------------------------------------------
  // Structure walk
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      load_idx_q <= '0;
      widx_q     <= '0;
      vld_q      <= 1'b0;
    end else begin
      if (start) begin
        load_idx_q <= '0;
      end else if (issue) begin
        load_idx_q <= load_idx_q + 1'b1;
      end
      vld_q  <= issue;
      widx_q <= load_idx_q;
    end
  end

  // Integers arrive low word first, so each shifts in from the top
  always_ff @(posedge mclk) begin
    if (vld_q) begin
      if (in_span(widx_q, `ESC_W(`ESC_OFF_MODULUS), NB / 32)) begin
        mod_q <= {word, mod_q[NB-1:32]};
      end
      if (in_span(widx_q, `ESC_W(`ESC_OFF_SIG), NB / 32)) begin
        sig_q <= {word, sig_q[NB-1:32]};
      end
      if (in_span(widx_q, `ESC_W(`ESC_OFF_Q1), NB / 32)) begin
        q1_q <= {word, q1_q[NB-1:32]};
      end
      if (in_span(widx_q, `ESC_W(`ESC_OFF_Q2), NB / 32)) begin
        q2_q <= {word, q2_q[NB-1:32]};
      end
    end
  end

  // Multi-word fields keep the lowest word at the low end of the vector
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fields_q <= '0;
    end else if (vld_q) begin
      if (in_span(widx_q, `ESC_W(`ESC_OFF_MEAS), `ESC_MEAS_WORDS)) begin
        fields_q.enclave_measurement <=
          {word, fields_q.enclave_measurement[255:32]};
      end
      if (in_span(widx_q, `ESC_W(`ESC_OFF_ATTR), `ESC_ID_WORDS)) begin
        fields_q.attributes <= {word, fields_q.attributes[127:32]};
      end
      if (in_span(widx_q, `ESC_W(`ESC_OFF_ATTRMASK), `ESC_ID_WORDS)) begin
        fields_q.attribute_enforce_mask <=
          {word, fields_q.attribute_enforce_mask[127:32]};
      end
      if (in_span(widx_q, `ESC_W(`ESC_OFF_FAMILY), `ESC_ID_WORDS)) begin
        fields_q.product_family_ident <=
          {word, fields_q.product_family_ident[127:32]};
      end
      if (in_span(widx_q, `ESC_W(`ESC_OFF_EXTPROD), `ESC_ID_WORDS)) begin
        fields_q.extended_product_ident <=
          {word, fields_q.extended_product_ident[127:32]};
      end
      case (widx_q)
        `ESC_W(`ESC_OFF_SELECT):
          fields_q.extended_frame_select <= word;
        `ESC_W(`ESC_OFF_SELMASK):
          fields_q.extended_frame_select_mask <= word;
        `ESC_W(`ESC_OFF_CFATTR): begin
          fields_q.control_flow_attr      <= word[7:0];
          fields_q.control_flow_attr_mask <= word[15:8];
        end
        `ESC_W(`ESC_OFF_PROD): begin
          fields_q.product_ident            <= word[15:0];
          fields_q.product_security_version <= word[31:16];
        end
        `ESC_W(`ESC_OFF_VENDOR): fields_q.vendor <= word;
        `ESC_W(`ESC_OFF_DATE):   fields_q.build_date <= word;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Field checks
  // ----------------------------------------------------------------
  // Errors clear only on start, which never meets a hardware set
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      err_q <= '0;
    end else if (start) begin
      err_q       <= '0;
      err_q.align <= (base_q[`ESC_PAGE_BITS-1:0] != '0);
    end else if (vld_q) begin
      if ((in_span(widx_q, `ESC_W(`ESC_OFF_HDR1), `ESC_ID_WORDS) ||
           in_span(widx_q, `ESC_W(`ESC_OFF_HDR2), `ESC_ID_WORDS)) &&
          (word != fixed_word(widx_q))) begin
        err_q.header <= 1'b1;
      end
      if ((widx_q == `ESC_W(`ESC_OFF_VENDOR)) &&
          (word != `ESC_VENDOR_OTHER) && (word != MAKER_VENDOR)) begin
        err_q.vendor <= 1'b1;
      end
      if ((widx_q == `ESC_W(`ESC_OFF_EXPONENT)) &&
          (word != `ESC_EXPONENT)) begin
        err_q.exponent <= 1'b1;
      end
      if ((in_span(widx_q, `ESC_W(`ESC_OFF_RSV0), `ESC_RSV0_WORDS) ||
           in_span(widx_q, `ESC_W(`ESC_OFF_RSV2), `ESC_RSV2_WORDS) ||
           in_span(widx_q, `ESC_W(`ESC_OFF_RSV3), `ESC_RSV3_WORDS)) &&
          (word != '0)) begin
        err_q.reserved <= 1'b1;
      end
      if ((widx_q == `ESC_W(`ESC_OFF_RSV1)) && (word[31:16] != '0)) begin
        err_q.reserved <= 1'b1;
      end
      if ((widx_q == `ESC_W(`ESC_OFF_SELECT)) && !frame_cap_q &&
          (word != '0)) begin
        err_q.frame_select <= 1'b1;
      end
      if ((widx_q == `ESC_W(`ESC_OFF_CFATTR)) && !cflow_cap_q &&
          (word[15:0] != '0)) begin
        err_q.control_flow <= 1'b1;
      end
    end else if ((state_q == ESC_MUL) && prod_done && phase_q[0]) begin
      if (diff_bad) begin
        err_q.quotient <= 1'b1;
      end
      if ((phase_q == 2'd3) && (diff[NB-1:0] != em)) begin
        err_q.signature <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cube modulo the key, by the supplied quotients
  // ----------------------------------------------------------------
  // Phases: s*s, q1*n, r1*s, q2*n; odd phases subtract from the held
  // product, trading a divider for two extra multiplies.
  assign acc_d     = mb_q[0] ? (acc_q + ma_q) : acc_q;
  assign prod_done = (cnt_q == `ESC_CNT_BITS'(NB - 1));
  assign diff      = {1'b0, hold_q} - {1'b0, acc_d};
  assign diff_bad  = diff[2*NB] || (diff[2*NB-1:NB] != '0) ||
                     (diff[NB-1:0] >= mod_q);

  always_comb begin
    case (phase_q)
      2'd0: begin
        next_a = q1_q;
        next_b = mod_q;
      end
      2'd1: begin
        next_a = diff[NB-1:0];
        next_b = sig_q;
      end
      default: begin
        next_a = q2_q;
        next_b = mod_q;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q   <= '0;
      ma_q    <= '0;
      mb_q    <= '0;
      hold_q  <= '0;
      cnt_q   <= '0;
      phase_q <= 2'd0;
    end else if (last_word) begin
      acc_q   <= '0;
      ma_q    <= {{NB{1'b0}}, sig_q};
      mb_q    <= sig_q;
      cnt_q   <= '0;
      phase_q <= 2'd0;
    end else if (state_q == ESC_MUL) begin
      if (prod_done) begin
        if (!phase_q[0]) begin
          hold_q <= acc_d;
        end
        acc_q   <= '0;
        ma_q    <= {{NB{1'b0}}, next_a};
        mb_q    <= next_b;
        cnt_q   <= '0;
        phase_q <= phase_q + 2'd1;
      end else begin
        acc_q <= acc_d;
        ma_q  <= {ma_q[2*NB-2:0], 1'b0};
        mb_q  <= {1'b0, mb_q[NB-1:1]};
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Padded digest: 00 01, fill, 00, DigestInfo prefix, digest
  generate
    for (genvar i = 0; i < `ESC_DIGEST_WORDS; i++) begin : g_dig
      assign digest_flat[255-32*i -: 32] = digest_q[i];
    end
  endgenerate
  assign em = {`ESC_EM_LEAD, {`ESC_EM_FILL{8'hff}}, 8'h00,
               `ESC_EM_PREFIX, digest_flat};

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      frame_cap_q <= 1'b0;
      cflow_cap_q <= 1'b0;
      base_q      <= '0;
      for (int i = 0; i < `ESC_DIGEST_WORDS; i++) begin
        digest_q[i] <= '0;
      end
    end else if (wr_strobe && (state_q == ESC_IDLE)) begin
      if (addr == `ESC_REG_CTRL) begin
        frame_cap_q <= wr_data[`ESC_CTRL_FRAME];
        cflow_cap_q <= wr_data[`ESC_CTRL_CFLOW];
      end
      if (addr == `ESC_REG_BASE) begin
        base_q <= wr_data;
      end
      for (int i = 0; i < `ESC_DIGEST_WORDS; i++) begin
        if (addr == `ESC_REG_DIGEST + 11'(i)) begin
          digest_q[i] <= wr_data;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= '0;
      if (rd_strobe) begin
        if (addr == `ESC_REG_CTRL) begin
          rd_data_q[`ESC_CTRL_FRAME] <= frame_cap_q;
          rd_data_q[`ESC_CTRL_CFLOW] <= cflow_cap_q;
        end
        if (addr == `ESC_REG_BASE) begin
          rd_data_q <= base_q;
        end
        if (addr == `ESC_REG_STATUS) begin
          rd_data_q[`ESC_ST_BUSY] <= busy_q;
          rd_data_q[`ESC_ST_DONE] <= (state_q == ESC_IDLE) && !busy_q;
          rd_data_q[`ESC_ST_PASS] <= pass_q;
          rd_data_q[`ESC_ST_ERR_LSB +: $bits(esc_errors_t)] <= err_q;
        end
        for (int i = 0; i < `ESC_DIGEST_WORDS; i++) begin
          if (addr == `ESC_REG_DIGEST + 11'(i)) begin
            rd_data_q <= digest_q[i];
          end
        end
      end
    end
  end
endmodule

/* esc_checker_assertions.sv */
// Purpose: Port assertions for esc_checker
// Assumes: One clock, reset_n async low
// Notes:   Bound below the module
`timescale 1ns/100ps
`include "esc_defs.svh"
module esc_checker_sva
  import esc_pkg::*;
(
  // Bus in
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [10:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_strobe,
  input wire logic        rd_strobe,
  // Results
  input wire logic [31:0] rd_data_q,
  input wire logic        busy_q,
  input wire logic        done_q,
  input wire logic        pass_q,
  input wire esc_fields_t fields_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire go = wr_strobe && addr == `ESC_REG_CTRL && wr_data[0] && !busy_q;
  a_read_quiet: assert property (!$past(rd_strobe) |-> rd_data_q == '0)
    else $error("read data outside read slot");
  a_status_busy: assert property (rd_strobe && addr == `ESC_REG_STATUS
    |=> rd_data_q[0] == $past(busy_q)) else $error("status busy bit");
  a_start_busy: assert property (go |-> ##[1:2] (busy_q || done_q))
    else $error("start not taken");
  a_pass_clear: assert property (go |-> ##2 !pass_q)
    else $error("pass kept over start");
  a_pass_done: assert property ($rose(pass_q) |-> done_q)
    else $error("pass rose without done");
  a_done_pulse: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");
  a_done_idle: assert property (done_q |-> !busy_q)
    else $error("busy with done");
  a_busy_drop: assert property ($fell(busy_q) |-> done_q)
    else $error("busy fell without done");
  a_fields_hold: assert property (!busy_q && !$past(busy_q) && !$past(go)
    && !$past(go, 2) |-> $stable(fields_q)) else $error("fields moved");
  c_start: cover property (go);
  c_fail: cover property (done_q && !pass_q);
  c_read: cover property (rd_strobe ##1 rd_data_q != '0);
  c_pass: cover property ($rose(pass_q));
endmodule
bind esc_checker esc_checker_sva u_sva (.mclk(mclk), .reset_n(reset_n),
  .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .rd_data_q(rd_data_q), .busy_q(busy_q),
  .done_q(done_q), .pass_q(pass_q), .fields_q(fields_q));

/* esc_checker_tb.sv */
// Purpose: Self-checking bench for esc_checker
// Assumes: Whole window written before a full check
// Notes:   Passing key is the padded digest plus one
`timescale 1ns/100ps
`include "esc_defs.svh"
module esc_checker_tb;
  import esc_pkg::*;
  logic        mclk, reset_n, wr_strobe, rd_strobe, busy_q, done_q, pass_q;
  logic [10:0] addr;
  logic [31:0] wr_data, rd_data_q, r;
  esc_fields_t fields_q;
  int          err_count = 0, compares = 0, cyc = 0;
  esc_checker uut (.mclk(mclk), .reset_n(reset_n), .addr(addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rd_data_q(rd_data_q), .busy_q(busy_q), .done_q(done_q),
    .pass_q(pass_q), .fields_q(fields_q));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Three full checks and the window writes take about 40k cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(logic [10:0] a, logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge mclk);
    wr_strobe <= 1'b0;
  endtask
  task automatic rd(logic [10:0] a);
    @(posedge mclk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge mclk);
    rd_strobe <= 1'b0;
    @(negedge mclk);
    r = rd_data_q;
  endtask
  // Start with capability bits {control flow, frame}, wait, read status
  task automatic run(logic [1:0] cap, logic exp_pass);
    int n;
    n = 0;
    wr(`ESC_REG_CTRL, {29'h0, cap, 1'b1});
    @(negedge mclk);
    chk("busy", 32'h1, 32'(busy_q));
    while (done_q !== 1'b1 && n < 14000) begin
      @(negedge mclk);
      n++;
    end
    chk("done", 32'h1, 32'(done_q));
    chk("busy end", 32'h0, 32'(busy_q));
    chk("pass out", 32'(exp_pass), 32'(pass_q));
    rd(`ESC_REG_STATUS);
  endtask
  task automatic t_align();
    wr(`ESC_REG_BASE, 32'h00001010);
    run(2'b00, 1'b0);
    chk("align err", 32'h1, 32'(r[4]));
    chk("pass", 32'h0, 32'(r[2]));
    rd(11'h003);
    chk("unmapped", 32'h0, r);
  endtask
  task automatic t_caps_zero();
    logic [31:0] hw [8] = '{`ESC_HDR1_W0, `ESC_HDR1_W1, `ESC_HDR1_W2,
      `ESC_HDR1_W3, `ESC_HDR2_W0, `ESC_HDR2_W1, `ESC_HDR2_W2, `ESC_HDR2_W3};
    wr(`ESC_REG_BASE, 32'h00002000);
    for (int k = 0; k < 452; k++) wr(11'h400 + 11'(k), 32'h0);
    for (int k = 0; k < 8; k++) wr(11'h400 + 11'(k < 4 ? k : k + 2), hw[k]);
    wr(11'h480, `ESC_EXPONENT);
    wr(11'h4e1, 32'h00000001);
    wr(11'h4e3, 32'h00000201);
    wr(11'h40b, 32'h00000001);
    wr(11'h4f0, 32'ha5a50001);
    wr(11'h500, 32'h00020001);
    run(2'b00, 1'b0);
    chk("errors", 32'h1f0, 32'(r[12:4]));
    chk("prod", 32'h1, 32'(fields_q.product_ident));
    chk("svn", 32'h2, 32'(fields_q.product_security_version));
    chk("meas", 32'ha5a50001, fields_q.enclave_measurement[31:0]);
    chk("cflow", 32'h201, {16'h0, fields_q.control_flow_attr_mask,
      fields_q.control_flow_attr});
    chk("select", 32'h1, fields_q.extended_frame_select);
  endtask
  task automatic t_bad_hdr();
    wr(11'h400, 32'h00000007);
    wr(11'h404, 32'h00001234);
    wr(11'h480, 32'h00000005);
    wr(11'h40b, 32'h00000000);
    run(2'b11, 1'b0);
    chk("errors", 32'h18e, 32'(r[12:4]));
  endtask
  // Key is padded digest plus one, so the signature cubes to minus one
  task automatic t_pass();
    logic [3071:0] em;
    logic [31:0]   w;
    em = {`ESC_EM_LEAD, {`ESC_EM_FILL{8'hff}}, 8'h00, `ESC_EM_PREFIX,
      224'h0, 32'h2};
    wr(`ESC_REG_DIGEST + 11'h7, 32'h2);
    wr(11'h400, `ESC_HDR1_W0);
    wr(11'h404, `ESC_VENDOR_OTHER);
    wr(11'h405, 32'h00010101);
    wr(11'h40a, 32'h5a5a5a5a);
    wr(11'h480, `ESC_EXPONENT);
    for (int k = 0; k < 96; k++) begin
      w = em[32*k +: 32];
      wr(11'h420 + 11'(k), w + 32'(k == 0));
      wr(11'h481 + 11'(k), w);
      wr(11'h504 + 11'(k), w - 32'(k == 0));
    end
    run(2'b11, 1'b1);
    chk("errors", 32'h0, 32'(r[12:4]));
    chk("date", 32'h00010101, fields_q.build_date);
    rd(`ESC_REG_DIGEST + 11'h7);
    chk("digest", 32'h2, r);
  endtask
  initial begin
    reset_n = 1'b0;
    addr = 11'h000;
    wr_data = 32'h0;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    t_align();
    t_caps_zero();
    t_bad_hdr();
    t_pass();
    close_out();
  end
endmodule

/* esc_defs.svh */
// Purpose: Constants of the enclave signature checker
// Assumes: Word index of a structure field is its byte offset over four
// Notes:   Register addresses are word addresses on the plain port
`ifndef ESC_DEFS_SVH
`define ESC_DEFS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define ESC_INT_BITS     3072
`define ESC_INT_BYTES    384
`define ESC_STRUCT_WORDS 452
`define ESC_IDX_BITS     9
`define ESC_ADDR_BITS    11
`define ESC_PAGE_BITS    12
`define ESC_CNT_BITS     12

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ESC_REG_CTRL     11'h000
`define ESC_REG_BASE     11'h001
`define ESC_REG_STATUS   11'h002
`define ESC_REG_DIGEST   11'h008
`define ESC_DIGEST_WORDS 8
`define ESC_REG_WINDOW   11'h400
`define ESC_CTRL_START   0
`define ESC_CTRL_FRAME   1
`define ESC_CTRL_CFLOW   2
`define ESC_ST_BUSY      0
`define ESC_ST_DONE      1
`define ESC_ST_PASS      2
`define ESC_ST_ERR_LSB   4

// ----------------------------------------------------------------
// Structure layout, byte offsets
// ----------------------------------------------------------------
`define ESC_W(off)       9'((off) / 4)
`define ESC_OFF_HDR1     0
`define ESC_OFF_VENDOR   16
`define ESC_OFF_DATE     20
`define ESC_OFF_HDR2     24
`define ESC_OFF_SWDEF    40
`define ESC_OFF_RSV0     44
`define ESC_OFF_MODULUS  128
`define ESC_OFF_EXPONENT 512
`define ESC_OFF_SIG      516
`define ESC_OFF_SELECT   900
`define ESC_OFF_SELMASK  904
`define ESC_OFF_CFATTR   908
`define ESC_OFF_RSV1     910
`define ESC_OFF_FAMILY   912
`define ESC_OFF_ATTR     928
`define ESC_OFF_ATTRMASK 944
`define ESC_OFF_MEAS     960
`define ESC_OFF_RSV2     992
`define ESC_OFF_EXTPROD  1008
`define ESC_OFF_PROD     1024
`define ESC_OFF_RSV3     1028
`define ESC_OFF_Q1       1040
`define ESC_OFF_Q2       1424
`define ESC_RSV0_WORDS   21
`define ESC_RSV2_WORDS   4
`define ESC_RSV3_WORDS   3
`define ESC_ID_WORDS     4
`define ESC_MEAS_WORDS   8

// ----------------------------------------------------------------
// Fixed contents
// ----------------------------------------------------------------
`define ESC_HDR1_W0      32'h00000006
`define ESC_HDR1_W1      32'h000000e1
`define ESC_HDR1_W2      32'h00100000
`define ESC_HDR1_W3      32'h00000000
`define ESC_HDR2_W0      32'h00000101
`define ESC_HDR2_W1      32'h00000060
`define ESC_HDR2_W2      32'h00000060
`define ESC_HDR2_W3      32'h00000001
`define ESC_EXPONENT     32'h00000003
`define ESC_VENDOR_OTHER 32'h00000000
`define ESC_EM_LEAD      16'h0001
`define ESC_EM_FILL      330
`define ESC_EM_PREFIX    152'h3031300d060960864801650304020105000420

`endif

/* esc_pkg.sv */
// Purpose: Types of the enclave signature checker
// Assumes: esc_defs.svh holds every number but the state codes and MAKER_VENDOR
// Notes:   Field record goes to the enclave init leaf logic
package esc_pkg;
`include "esc_defs.svh"

  typedef enum logic [3:0] {
    ESC_IDLE = 4'b0001,
    ESC_LOAD = 4'b0010,
    ESC_MUL  = 4'b0100,
    ESC_DONE = 4'b1000
  } esc_state_t;

  typedef struct packed {
    logic [255:0] enclave_measurement;
    logic [127:0] attributes;
    logic [127:0] attribute_enforce_mask;
    logic [127:0] product_family_ident;
    logic [127:0] extended_product_ident;
    logic [31:0]  extended_frame_select;
    logic [31:0]  extended_frame_select_mask;
    logic [7:0]   control_flow_attr;
    logic [7:0]   control_flow_attr_mask;
    logic [15:0]  product_ident;
    logic [15:0]  product_security_version;
    logic [31:0]  vendor;
    logic [31:0]  build_date;
  } esc_fields_t;

  typedef struct packed {
    logic signature;
    logic quotient;
    logic control_flow;
    logic frame_select;
    logic reserved;
    logic exponent;
    logic vendor;
    logic header;
    logic align;
  } esc_errors_t;
endpackage

/* esc_word_mem.sv */
// Purpose: Word buffer holding one enclave_signature_structure
// Assumes: One write port and one read port on mclk
// Notes:   Read data come out of a register one cycle after rd_en
`timescale 1ns/100ps
module esc_word_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 452,
  parameter int AW    = 9
) (
  // Clock
  input  wire logic             mclk,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_q
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rd_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule
